//--- pcs_map.svh
/*
  Offsets, field positions, reset values and constants of the per-port
  configuration space. Definitions only; included by the modules.
*/
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

// dword-aligned byte offsets of the configuration space
`define PCS_OFF_ID 12'h000
`define PCS_OFF_CMD 12'h004
`define PCS_OFF_CLASS 12'h008
`define PCS_OFF_HDR 12'h00c
`define PCS_OFF_BUS 12'h018
`define PCS_OFF_CAPPTR 12'h034
`define PCS_OFF_MSI 12'h040
`define PCS_OFF_MSI_ADDR 12'h044
`define PCS_OFF_MSI_DATA 12'h048
`define PCS_OFF_HP 12'h050
`define PCS_OFF_HP_SEL 12'h054
`define PCS_OFF_HP_DATA 12'h058
`define PCS_OFF_PM_SEL 12'h05c
`define PCS_OFF_PM_DATA 12'h060
`define PCS_OFF_PCIE 12'h070
`define PCS_OFF_EXT 12'h100

// field positions
`define PCS_CMD_DIS_BIT 10
`define PCS_MSI_EN_BIT 16

// reset values
`define PCS_DIS_RST 1'b0
`define PCS_BUS_RST 24'h000000

// fixed field values
`define PCS_ID_MSI 8'h05
`define PCS_ID_HP 8'h0c
`define PCS_ID_PCIE 8'h10
`define PCS_ID_EXT_ERR 16'h0001
`define PCS_EXT_VER 4'h1
`define PCS_EXT_NEXT 12'h000
`define PCS_PCIE_CAPREG 16'h0041
`define PCS_CLASS_CODE 24'h060400
`define PCS_HDR_TYPE 8'h01
`define PCS_ABORT_DATA 32'hffffffff

// device numbering
`define PCS_DEV_SBL 3'h0
`define PCS_DEV_EMPTY 3'h1
`define PCS_SEL_W 3

`endif

//--- pcs_pkg.sv
/*
  Types of the port configuration space: link widths, access states and the
  packed state records of the access controller and the working-set memory. Assumes pcs_map.svh on the include path.
*/
package pcs_pkg;

  typedef enum logic [1:0] {PCS_W_NONE, PCS_W_X4, PCS_W_X8, PCS_W_X16} pcs_width_t;

  typedef enum logic [0:0] {PCS_IDLE, PCS_MEM} pcs_fsm_t;

  typedef struct packed {
    pcs_fsm_t fsm;
    logic ack;
    logic abort;
    logic [31:0] rdata;
    logic [7:0] dis;
    pcs_width_t [7:0] width;
    logic [7:0] acc;
    logic [7:0][2:0] hp_sel;
    logic [7:0][2:0] pm_sel;
    logic [7:0][23:0] bus;
    logic [7:0] msi_en;
    logic [7:0][31:0] msi_addr;
    logic [7:0][15:0] msi_data;
    logic [7:0] irq;
    logic [7:0] fwd;
  } pcs_state_t;

  typedef struct packed {
    logic [127:0][31:0] word;
    logic [31:0] rdata;
  } pcs_mem_state_t;

endpackage : pcs_pkg

//--- pcs_wset_if.sv
/*
  Carrier between the access controller and the working-set memory.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface pcs_wset_if;
  logic wr;
  logic rd;
  logic [6:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;

  modport ctrl (output wr, output rd, output addr, output wdata, input rdata);
  modport mem (input wr, input rd, input addr, input wdata, output rdata);
endinterface : pcs_wset_if

//--- pcs_port_gate.sv
/*
  Decides whether one port's registers are reachable from its trained width.
  Assumes the width is already captured on the hub clock.
*/
`timescale 1ns/1ps
`include "pcs_map.svh"
module pcs_port_gate
  import pcs_pkg::*;
#(
  parameter logic [2:0] DEV = 3'h0
)(
  // trained width in
  input pcs_width_t width,
  // reachability out
  output logic accessible
);
  always_comb
  begin
    if (DEV == `PCS_DEV_SBL)
      accessible = 1'b1;
    else if (DEV == `PCS_DEV_EMPTY)
      accessible = 1'b0;
    else if (DEV[0])
      accessible = (width == PCS_W_NONE) || (width == PCS_W_X4);
    else
      accessible = (width != PCS_W_X16);
  end
endmodule : pcs_port_gate

//--- pcs_wset_mem.sv
/*
  Working-set register memory for hot-plug and power-management sets,
  128 words, read data registered. Assumes one request per cycle at most.
*/
`timescale 1ns/1ps
module pcs_wset_mem
  import pcs_pkg::*;
(
  // clocking
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // access port
  pcs_wset_if.mem mif
);
  pcs_mem_state_t st;
  pcs_mem_state_t next_st;

  assign mif.rdata = st.rdata;

  always_comb
  begin
    next_st = st;
    if (mif.wr)
      next_st.word[mif.addr] = mif.wdata;
    if (mif.rd)
      next_st.rdata = st.word[mif.addr];
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      st <= '0;
    else if (ce)
      st <= next_st;
  end
endmodule : pcs_wset_mem

//--- pcs_port_config_space.sv
/*
  Configuration-space front end for the hub's root ports 0 and 2..7:
  access gating by trained width, master abort, header, capability list,
  extended space, indirect working sets and legacy interrupt gating.
  Assumes configuration requests, training results and port events all
  come from logic on mclk; requests are taken only while idle.
*/
// Functional notes
// - ports 2..7 answer as devices 2..7, southbridge link as device 0.
// - the trained width of ports 2..7 is captured and steers register access.
// - every port device stays visible even with nothing attached.
// - absorbed ports master-abort: reads give all ones, writes dropped.
// - ports with no attached device still accept configuration accesses.
// - even ports 2, 4, 6 reachable when trained x4 or x8.
// - odd ports 3, 5, 7 reachable only when trained x4 or unconnected.
// - port 0 is always a x4 southbridge link, never merged.
// - each port shows a bridge-style header.
// - capabilities form a linked list of next pointers.
// - first extended capability sits at offset 0x100.
// - device region holds exactly MSI, hot-plug and PCIe capabilities.
// - extended space holds error signalling, reached only by extended accesses.
// - hot-plug and power-management sets are reached via select then data.
// - command bits 15:11 are reserved and read zero.
// - command bit 10 resets to 0; set disables legacy interrupts.
// - interrupt disable never blocks forwarding of received interrupt messages.
// - disabled ports send no legacy interrupt for errors or hot-plug/pm events.
`timescale 1ns/1ps
`include "pcs_map.svh"
module pcs_port_config_space
  import pcs_pkg::*;
#(
  parameter logic [15:0] VENDOR_ID = 16'h0a5a, // arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h0c3c, // arbitrary value
  parameter logic [7:0] REVISION_ID = 8'h01 // arbitrary value
)(
  // clocking
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // configuration access
  input wire logic cfg_req,
  input wire logic cfg_wr,
  input wire logic cfg_ext,
  input wire logic [4:0] cfg_dev,
  input wire logic [2:0] cfg_func,
  input wire logic [11:0] cfg_off,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic cfg_abort,
  output logic [31:0] cfg_rdata,
  // link training results
  input wire logic [7:0] train_done,
  input pcs_width_t [7:0] train_width,
  // port events
  input wire logic [7:0] err_int,
  input wire logic [7:0] err_msg,
  input wire logic [7:0] hppm_evt,
  input wire logic [7:0] rx_int_msg,
  // toward the hub
  output logic [7:0] hub_interrupt_path_req,
  output logic [7:0] hub_msg_fwd,
  output logic [7:0] port_accessible
);
  pcs_state_t st;
  pcs_state_t next_st;
  pcs_wset_if mif ();
  logic [7:0] gate_acc;
  logic [2:0] dev;
  logic [11:0] dw_off;
  logic dev_ok;
  logic hit;
  logic ext_blk;
  logic [31:0] rd_val;
  logic take;

  pcs_wset_mem u_mem (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .mif(mif)
  );

  // one gate per device slot; slot 1 is empty
  for (genvar g = 0; g < 8; g++)
  begin : g_gate
    pcs_port_gate #(.DEV(3'(g))) u_gate (
      .width(st.width[g]),
      .accessible(gate_acc[g])
    );
  end

  assign cfg_ack = st.ack;
  assign cfg_abort = st.abort;
  assign cfg_rdata = st.rdata;
  assign hub_interrupt_path_req = st.irq;
  assign hub_msg_fwd = st.fwd;
  assign port_accessible = st.acc;

  assign dev = cfg_dev[2:0];
  assign dw_off = {cfg_off[11:2], 2'b00};
  // devices 0, 2..7 exist whether or not a link came up
  assign dev_ok = (cfg_dev[4:3] == 2'b00) && (dev != `PCS_DEV_EMPTY) && (cfg_func == 3'h0);
  assign hit = dev_ok && st.acc[dev];
  // plain accesses cannot reach the extended space
  assign ext_blk = (cfg_off[11:8] != 4'h0) && !cfg_ext;

  // read view of the port's space
  always_comb
  begin
    rd_val = 32'h0;
    unique case (dw_off)
      `PCS_OFF_ID: rd_val = {DEVICE_ID, VENDOR_ID};
      `PCS_OFF_CMD: rd_val = {16'h0, 5'h0, st.dis[dev], 10'h0};
      `PCS_OFF_CLASS: rd_val = {`PCS_CLASS_CODE, REVISION_ID};
      `PCS_OFF_HDR: rd_val = {8'h0, `PCS_HDR_TYPE, 16'h0};
      `PCS_OFF_BUS: rd_val = {8'h0, st.bus[dev]};
      `PCS_OFF_CAPPTR: rd_val = {20'h0, `PCS_OFF_MSI};
      `PCS_OFF_MSI: rd_val = {15'h0, st.msi_en[dev], 8'(`PCS_OFF_HP), `PCS_ID_MSI};
      `PCS_OFF_MSI_ADDR: rd_val = st.msi_addr[dev];
      `PCS_OFF_MSI_DATA: rd_val = {16'h0, st.msi_data[dev]};
      `PCS_OFF_HP: rd_val = {16'h0, 8'(`PCS_OFF_PCIE), `PCS_ID_HP};
      `PCS_OFF_HP_SEL: rd_val = {29'h0, st.hp_sel[dev]};
      `PCS_OFF_PM_SEL: rd_val = {29'h0, st.pm_sel[dev]};
      `PCS_OFF_PCIE: rd_val = {`PCS_PCIE_CAPREG, 8'h00, `PCS_ID_PCIE};
      `PCS_OFF_EXT: rd_val = {`PCS_EXT_NEXT, `PCS_EXT_VER, `PCS_ID_EXT_ERR};
      default: rd_val = 32'h0;
    endcase
  end

  always_comb
  begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.abort = 1'b0;
    mif.wr = 1'b0;
    mif.rd = 1'b0;
    mif.wdata = cfg_wdata;
    mif.addr = {dev, 1'b0, st.hp_sel[dev]};
    if (dw_off == `PCS_OFF_PM_DATA)
      mif.addr = {dev, 1'b1, st.pm_sel[dev]};
    next_st.acc = gate_acc;
    for (int i = 0; i < 8; i++)
    begin
      // width is re-captured each time training completes
      if (train_done[i])
        next_st.width[i] = train_width[i];
      // legacy interrupts only while enabled; messages always pass
      next_st.irq[i] = (err_int[i] || err_msg[i] || hppm_evt[i])
        && !st.dis[i] && gate_acc[i];
      next_st.fwd[i] = rx_int_msg[i];
    end
    next_st.width[1] = PCS_W_NONE;
    next_st.width[0] = PCS_W_X4;
    unique case (st.fsm)
      PCS_IDLE:
      begin
        if (cfg_req)
        begin
          next_st.ack = 1'b1;
          next_st.rdata = 32'h0;
          if (!hit)
          begin
            next_st.abort = 1'b1;
            next_st.rdata = `PCS_ABORT_DATA;
          end
          else if (ext_blk)
            next_st.rdata = 32'h0;
          else if (cfg_wr)
          begin
            unique case (dw_off)
              `PCS_OFF_CMD:
              begin
                // only bit 10 has storage; reserved bits fall away
                if (cfg_be[1])
                  next_st.dis[dev] = cfg_wdata[`PCS_CMD_DIS_BIT];
              end
              `PCS_OFF_BUS:
              begin
                for (int b = 0; b < 3; b++)
                  if (cfg_be[b])
                    next_st.bus[dev][b*8 +: 8] = cfg_wdata[b*8 +: 8];
              end
              `PCS_OFF_MSI:
              begin
                if (cfg_be[2])
                  next_st.msi_en[dev] = cfg_wdata[`PCS_MSI_EN_BIT];
              end
              `PCS_OFF_MSI_ADDR:
              begin
                for (int b = 0; b < 4; b++)
                  if (cfg_be[b])
                    next_st.msi_addr[dev][b*8 +: 8] = cfg_wdata[b*8 +: 8];
                next_st.msi_addr[dev][1:0] = 2'b00;
              end
              `PCS_OFF_MSI_DATA:
              begin
                for (int b = 0; b < 2; b++)
                  if (cfg_be[b])
                    next_st.msi_data[dev][b*8 +: 8] = cfg_wdata[b*8 +: 8];
              end
              `PCS_OFF_HP_SEL:
              begin
                if (cfg_be[0])
                  next_st.hp_sel[dev] = cfg_wdata[`PCS_SEL_W-1:0];
              end
              `PCS_OFF_PM_SEL:
              begin
                if (cfg_be[0])
                  next_st.pm_sel[dev] = cfg_wdata[`PCS_SEL_W-1:0];
              end
              `PCS_OFF_HP_DATA, `PCS_OFF_PM_DATA:
                mif.wr = 1'b1;
              default:
                next_st.rdata = 32'h0;
            endcase
          end
          else if (dw_off == `PCS_OFF_HP_DATA || dw_off == `PCS_OFF_PM_DATA)
          begin
            // memory read data lands one cycle later
            mif.rd = 1'b1;
            next_st.ack = 1'b0;
            next_st.fsm = PCS_MEM;
          end
          else
            next_st.rdata = rd_val;
        end
      end
      PCS_MEM:
      begin
        next_st.ack = 1'b1;
        next_st.rdata = mif.rdata;
        next_st.fsm = PCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      st <= '0;
      st.fsm <= PCS_IDLE;
      st.dis <= {8{`PCS_DIS_RST}};
      st.bus <= {8{`PCS_BUS_RST}};
      st.width <= {8{PCS_W_NONE}};
      st.acc <= 8'h00;
    end
    else if (ce)
      st <= next_st;
  end

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst || !ce);

  // a request the controller takes this cycle
  assign take = (st.fsm == PCS_IDLE) && cfg_req;

  abort_read_ones_a: assert property (
    take && dev_ok && !st.acc[dev] && !cfg_wr
      |=> cfg_ack && cfg_abort && cfg_rdata == 32'hffffffff)
    else $error("absorbed port read did not return all ones");

  abort_write_drop_a: assert property (
    take && !hit && cfg_wr |=> $stable(st.dis) && $stable(st.bus))
    else $error("write to absorbed port changed state");

  width_capture_a: assert property (
    train_done[6] |=> st.width[6] == $past(train_width[6]))
    else $error("trained width not captured");

  odd_x8_blocked_a: assert property (
    st.width[3] == PCS_W_X8 |=> !port_accessible[3])
    else $error("odd port reachable while absorbed");

  even_x8_open_a: assert property (
    st.width[2] == PCS_W_X8 |=> port_accessible[2])
    else $error("even x8 port not reachable");

  unconnected_open_a: assert property (
    st.width[5] == PCS_W_NONE |=> port_accessible[5])
    else $error("unconnected port not reachable");

  port0_fixed_a: assert property (
    !$past(srst) && $past(ce) |-> port_accessible[0] && st.width[0] == PCS_W_X4)
    else $error("southbridge port not fixed x4");

  cmd_reserved_a: assert property (
    take && hit && !cfg_wr && !ext_blk && dw_off == 12'h004
      |=> cfg_ack && cfg_rdata[31:11] == 21'h0 && cfg_rdata[9:0] == 10'h0)
    else $error("reserved command bits not zero");

  intx_blocked_a: assert property (
    st.dis[2] && (err_int[2] || err_msg[2] || hppm_evt[2]) |=> !hub_interrupt_path_req[2])
    else $error("legacy interrupt sent while disabled");

  intx_sent_a: assert property (
    !st.dis[2] && gate_acc[2] && err_int[2] |=> hub_interrupt_path_req[2])
    else $error("legacy interrupt lost while enabled");

  msg_forward_a: assert property (
    rx_int_msg[7] |=> hub_msg_fwd[7])
    else $error("received interrupt message not forwarded");

  ext_base_a: assert property (
    take && hit && cfg_ext && !cfg_wr && dw_off == 12'h100
      |=> cfg_rdata[15:0] == 16'h0001)
    else $error("extended capability missing at base");

  wset_latency_a: assert property (
    take && hit && !cfg_wr && !ext_blk && dw_off == 12'h058
      |=> !cfg_ack ##1 cfg_ack && !cfg_abort)
    else $error("working set read latency wrong");

  empty_slot_abort_a: assert property (
    take && cfg_dev == 5'h01 |=> cfg_ack && cfg_abort)
    else $error("empty device slot answered");

  ext_plain_zero_a: assert property (
    take && hit && ext_blk && !cfg_wr
      |=> cfg_ack && !cfg_abort && cfg_rdata == 32'h0)
    else $error("extended space reached by plain access");

  cmd_mask_keep_a: assert property (
    take && hit && cfg_wr && dw_off == 12'h004 && !cfg_be[1]
      |=> $stable(st.dis))
    else $error("masked command write changed state");

  cap_chain_a: assert property (
    take && hit && !cfg_wr && !ext_blk && dw_off == 12'h034
      |=> cfg_rdata == 32'h00000040)
    else $error("capability pointer wrong");

  port0_no_abort_a: assert property (
    take && !$past(srst) && $past(ce) && cfg_dev == 5'h00 && cfg_func == 3'h0
      |=> !cfg_abort)
    else $error("southbridge port aborted");

  hp_sel_store_a: assert property (
    take && hit && cfg_wr && dw_off == 12'h054 && cfg_be[0]
      |=> st.hp_sel[$past(dev)] == $past(cfg_wdata[2:0]))
    else $error("hot-plug select not stored");

  abort_seen_c: cover property (take ##1 cfg_abort);
  disable_set_c: cover property (st.dis[2] ##1 err_int[2]);
  wset_read_c: cover property (st.fsm == PCS_MEM ##1 cfg_ack);
  ext_access_c: cover property (take && cfg_ext ##1 cfg_ack);
endmodule : pcs_port_config_space

//--- tb_pcs_port_config_space.sv
/*
  Self-checking bench for the port configuration space: table of config
  accesses, then working sets, refusal, interrupt gating, reset by hand.
  Assumes pcs_pkg, pcs_map.svh and the design files are compiled first.
*/
`timescale 1ns/1ps
module tb_pcs_port_config_space
  import pcs_pkg::*;
;
  typedef struct packed {
    logic w;
    logic e;
    logic [4:0] dev;
    logic [2:0] fn;
    logic [11:0] off;
    logic [3:0] be;
    logic [31:0] wd;
    logic ab;
    logic [31:0] rd;
  } pcs_tb_row_t;

  // clocking
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  // configuration access
  logic cfg_req, cfg_wr, cfg_ext;
  logic [4:0] cfg_dev;
  logic [2:0] cfg_func;
  logic [11:0] cfg_off;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic cfg_ack, cfg_abort;
  // training and events
  logic [7:0] train_done, err_int, err_msg, hppm_evt, rx_int_msg;
  pcs_width_t [7:0] train_width;
  logic [7:0] hub_interrupt_path_req, hub_msg_fwd, port_accessible;

  int mismatches = 0;
  int checks = 0;
  logic got_ab;
  logic [31:0] got_rd;
  logic [7:0] got_lat;

  // port 2 x8, 3 x8 (absorbed), 4 x16 (absorbed), 5/6 x4, 7 unconnected
  pcs_tb_row_t rows [19] = '{
    '{1'h0,1'h0,5'h02,3'h0,12'h004,4'hf,32'h0,1'h0,32'h0},
    '{1'h1,1'h0,5'h02,3'h0,12'h004,4'hf,32'hffffffff,1'h0,32'h0},
    '{1'h0,1'h0,5'h02,3'h0,12'h004,4'hf,32'h0,1'h0,32'h00000400},
    '{1'h1,1'h0,5'h02,3'h0,12'h004,4'hd,32'h0,1'h0,32'h0},
    '{1'h0,1'h0,5'h02,3'h0,12'h004,4'hf,32'h0,1'h0,32'h00000400},
    '{1'h1,1'h0,5'h03,3'h0,12'h004,4'hf,32'h0,1'h1,32'hffffffff},
    '{1'h0,1'h0,5'h05,3'h0,12'h004,4'hf,32'h0,1'h0,32'h0},
    '{1'h0,1'h0,5'h04,3'h0,12'h004,4'hf,32'h0,1'h1,32'hffffffff},
    '{1'h0,1'h0,5'h07,3'h0,12'h004,4'hf,32'h0,1'h0,32'h0},
    '{1'h0,1'h0,5'h00,3'h0,12'h008,4'hf,32'h0,1'h0,32'h06040001},
    '{1'h0,1'h0,5'h01,3'h0,12'h004,4'hf,32'h0,1'h1,32'hffffffff},
    '{1'h0,1'h0,5'h08,3'h0,12'h004,4'hf,32'h0,1'h1,32'hffffffff},
    '{1'h0,1'h0,5'h02,3'h1,12'h004,4'hf,32'h0,1'h1,32'hffffffff},
    '{1'h0,1'h0,5'h06,3'h0,12'h034,4'hf,32'h0,1'h0,32'h00000040},
    '{1'h0,1'h0,5'h06,3'h0,12'h040,4'hf,32'h0,1'h0,32'h00005005},
    '{1'h0,1'h0,5'h06,3'h0,12'h050,4'hf,32'h0,1'h0,32'h0000700c},
    '{1'h0,1'h0,5'h06,3'h0,12'h070,4'hf,32'h0,1'h0,32'h00410010},
    '{1'h0,1'h1,5'h06,3'h0,12'h100,4'hf,32'h0,1'h0,32'h00010001},
    '{1'h0,1'h0,5'h06,3'h0,12'h100,4'hf,32'h0,1'h0,32'h0}
  };

  pcs_port_config_space u_dut (
    .mclk(mclk), .srst(srst), .ce(ce),
    .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_ext(cfg_ext), .cfg_dev(cfg_dev),
    .cfg_func(cfg_func), .cfg_off(cfg_off), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_ack(cfg_ack), .cfg_abort(cfg_abort), .cfg_rdata(cfg_rdata),
    .train_done(train_done), .train_width(train_width),
    .err_int(err_int), .err_msg(err_msg), .hppm_evt(hppm_evt), .rx_int_msg(rx_int_msg),
    .hub_interrupt_path_req(hub_interrupt_path_req), .hub_msg_fwd(hub_msg_fwd),
    .port_accessible(port_accessible)
  );

  always #50 mclk = ~mclk;

  task test_done;
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp32

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp8

  // one access; ends a cycle later so req is never re-raised in the same step
  task automatic acc(input logic w, input logic e, input logic [4:0] d,
      input logic [2:0] f, input logic [11:0] o, input logic [31:0] wd,
      input logic [3:0] b);
    int n;
    n = 0;
    cfg_req = 1'b1;
    cfg_wr = w;
    cfg_ext = e;
    cfg_dev = d;
    cfg_func = f;
    cfg_off = o;
    cfg_wdata = wd;
    cfg_be = b;
    @(posedge mclk);
    #1;
    cfg_req = 1'b0;
    while (cfg_ack !== 1'b1 && n < 4)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (cfg_ack !== 1'b1)
      mismatches++;
    got_ab = cfg_abort;
    got_rd = cfg_rdata;
    got_lat = 8'(n);
    @(posedge mclk);
    #1;
  endtask : acc

  // one-cycle event pulse, outputs checked one cycle later
  task automatic ev(input logic [7:0] ei, input logic [7:0] hp, input logic [7:0] rx,
      input logic [7:0] exp_irq, input logic [7:0] exp_fwd);
    err_int = ei;
    err_msg = 8'h00;
    hppm_evt = hp;
    rx_int_msg = rx;
    @(posedge mclk);
    #1;
    err_int = 8'h00;
    hppm_evt = 8'h00;
    rx_int_msg = 8'h00;
    cmp8(hub_interrupt_path_req, exp_irq);
    cmp8(hub_msg_fwd, exp_fwd);
    // idle cycle so the next pulse is not set in the step that cleared this one
    @(posedge mclk);
    #1;
  endtask : ev

  initial
  begin
    #(3000 * 100);
    mismatches++;
    test_done;
  end

  initial
  begin
    cfg_req = 1'b0;
    cfg_wr = 1'b0;
    cfg_ext = 1'b0;
    cfg_dev = 5'h00;
    cfg_func = 3'h0;
    cfg_off = 12'h000;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
    train_done = 8'h00;
    err_int = 8'h00;
    err_msg = 8'h00;
    hppm_evt = 8'h00;
    rx_int_msg = 8'h00;
    train_width = {PCS_W_NONE, PCS_W_X4, PCS_W_X4, PCS_W_X16,
                    PCS_W_X8, PCS_W_X8, PCS_W_NONE, PCS_W_X4};
    repeat (8) @(posedge mclk);
    #1;
    cmp8(port_accessible, 8'h00);
    cmp8(hub_interrupt_path_req, 8'h00);
    srst = 1'b0;
    @(posedge mclk);
    #1;
    cmp8(port_accessible, 8'hfd);
    @(posedge mclk);
    #1;
    cmp8(port_accessible, 8'hfd);
    train_done = 8'hff;
    @(posedge mclk);
    #1;
    train_done = 8'h00;
    @(posedge mclk);
    #1;
    cmp8(port_accessible, 8'he5);
    foreach (rows[i])
    begin
      acc(rows[i].w, rows[i].e, rows[i].dev, rows[i].fn, rows[i].off, rows[i].wd, rows[i].be);
      cmp8({7'h0, got_ab}, {7'h0, rows[i].ab});
      cmp32(got_rd, rows[i].rd);
    end
    // working sets: two hot-plug words and one power word, then read back
    acc(1'b1, 1'b0, 5'h02, 3'h0, 12'h054, 32'h3, 4'hf);
    acc(1'b1, 1'b0, 5'h02, 3'h0, 12'h058, 32'ha5a50001, 4'hf);
    acc(1'b1, 1'b0, 5'h02, 3'h0, 12'h054, 32'h4, 4'hf);
    acc(1'b1, 1'b0, 5'h02, 3'h0, 12'h058, 32'h0000beef, 4'hf);
    acc(1'b1, 1'b0, 5'h02, 3'h0, 12'h05c, 32'h3, 4'hf);
    acc(1'b1, 1'b0, 5'h02, 3'h0, 12'h060, 32'h12340000, 4'hf);
    acc(1'b1, 1'b0, 5'h02, 3'h0, 12'h054, 32'h3, 4'hf);
    acc(1'b0, 1'b0, 5'h02, 3'h0, 12'h060, 32'h0, 4'hf);
    cmp32(got_rd, 32'h12340000);
    cmp8(got_lat, 8'h01);
    // data read followed at once by a request that must be ignored
    cfg_off = 12'h058;
    cfg_wr = 1'b0;
    cfg_req = 1'b1;
    @(posedge mclk);
    #1;
    cfg_off = 12'h004;
    @(posedge mclk);
    #1;
    cfg_req = 1'b0;
    cmp8({7'h0, cfg_ack}, 8'h01);
    cmp32(cfg_rdata, 32'ha5a50001);
    repeat (2)
    begin
      @(posedge mclk);
      #1;
      cmp8({7'h0, cfg_ack}, 8'h00);
    end
    // port 2 disabled, port 3 absorbed, ports 0, 5, 6 enabled
    ev(8'h04, 8'h00, 8'h04, 8'h00, 8'h04);
    ev(8'h00, 8'h04, 8'h00, 8'h00, 8'h00);
    ev(8'h48, 8'h21, 8'h40, 8'h61, 8'h40);
    acc(1'b1, 1'b0, 5'h02, 3'h0, 12'h004, 32'h0, 4'hf);
    ev(8'h04, 8'h00, 8'h00, 8'h04, 8'h00);
    acc(1'b1, 1'b0, 5'h02, 3'h0, 12'h004, 32'h00000400, 4'hf);
    // second reset in mid-run clears the disable bit and widths
    srst = 1'b1;
    @(posedge mclk);
    #1;
    srst = 1'b0;
    @(posedge mclk);
    @(posedge mclk);
    #1;
    cmp8(port_accessible, 8'hfd);
    acc(1'b0, 1'b0, 5'h02, 3'h0, 12'h004, 32'h0, 4'hf);
    cmp32(got_rd, 32'h0);
    test_done;
  end
endmodule : tb_pcs_port_config_space
